// ===== src/rmt_top.sv
// Purpose: Receive matching, word packing, buffer writes and timed-token timers.
// Assumes: Receive bytes and all inputs are synchronous to clk_in.
// Notes: Timers count clk_in cycles while ce_in is high.
// Functional notes
// - Compare DA and SA to own address.
// - Source match strips the frame.
// - Destination match receives frame into FIFO.
// - External source match strips like internal.
// - External destination match (low) receives frame.
// - Check length, classify FC, report status.
// - Rotation timer reloads with negotiated time when ring operational, else TRT_INIT.
// - Token after timer expiry is late.
// - Second expiry without token starts claim.
// - Synchronous frames first, until allocation expires.
// - Holding count loaded at capture, runs after sync.
// - Holding expiry: finish frame, release token.
// - Async queues 0,1,2; grant if prio below count.
// - Walk remaining queues, then release token.
// - Valid-transmission timer expiry starts recovery.
// - Pack four bytes into one long word.
// - Separate write and read machines, length count.
// - FIFO ten entries, 32 data plus last flag.
// - Per-byte parity generate and check, odd/even.
// - Tag marks final stored word in tag mode.
// - 32-bit holding register, two 16-bit halves.
// - Soft reset, interrupt, pending transfer register.
// - All logic runs on the byte clock.
`timescale 1ns/1ns
module rmt_top #(
   parameter int TW = rmt_pkg::TIMER_W,
   parameter logic [rmt_pkg::TIMER_W-1:0] TRT_INIT = 16'hFFFF
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic ce_in,
   input wire logic long_addr_in,
   input wire logic [47:0] station_own_address_in,
   input wire logic ext_source_match_in,
   input wire logic ext_dest_match_in_n,
   input wire logic rx_valid_in,
   input wire logic rx_first_in,
   input wire logic rx_last_in,
   input wire logic [rmt_pkg::BYTE_W-1:0] rx_byte_in,
   output logic frame_status_valid_out,
   output logic [4:0] frame_status_out,
   output logic [1:0] fc_class_out,
   output logic rx_overflow_out,
   input wire logic ring_operational_in,
   input wire logic token_arrived_in,
   input wire logic token_capture_in,
   input wire logic [TW-1:0] negotiated_rotation_time_in,
   input wire logic [TW-1:0] sync_alloc_in,
   input wire logic [TW-1:0] tvx_max_in,
   input wire logic [3*TW-1:0] async_prio_in,
   input wire logic [3:0] queue_pending_in,
   input wire logic frame_done_in,
   output logic late_token_out,
   output logic claim_start_out,
   output logic ring_recovery_out,
   output logic token_release_out,
   output logic [2:0] tx_queue_out,
   output logic [TW-1:0] tht_out,
   input wire logic tag_mode_in,
   input wire logic parity_odd_in,
   input wire logic buf_grant_in,
   output logic buf_req_out,
   output logic buf_we_out,
   output logic [rmt_pkg::WORD_W-1:0] buffer_data_bus_out,
   output logic [3:0] buf_parity_out,
   output logic buffer_frame_end_tag_out,
   input wire logic buf_rd_valid_in,
   input wire logic [rmt_pkg::WORD_W-1:0] buffer_data_bus_in,
   input wire logic [3:0] buf_parity_in,
   output logic [3:0] parity_err_out,
   input wire logic [rmt_pkg::NP_W-1:0] np_data_in,
   input wire logic np_half_in,
   input wire logic np_wr_in,
   output logic [rmt_pkg::NP_W-1:0] np_data_out,
   input wire logic mdr_store_req_in,
   input wire logic mdr_fetch_req_in,
   output logic [1:0] mdr_pending_out,
   input wire logic np_soft_reset_in,
   output logic chip_reset_out,
   output logic np_irq_out
);
   import rmt_pkg::*;

   typedef enum logic [2:0] {
      RW_IDLE = 3'h0, RW_DA = 3'h1, RW_SA = 3'h2, RW_DATA = 3'h3
   } rmt_wr_state_t;
   typedef enum logic [1:0] {
      RD_IDLE = 2'h0, RD_RX = 2'h1, RD_STORE = 2'h2, RD_FETCH = 2'h3
   } rmt_rd_state_t;
   typedef enum logic [2:0] {
      TX_IDLE = 3'h0, TX_SYNC = 3'h1, TX_CHECK = 3'h2, TX_ASYNC = 3'h3, TX_RELEASE = 3'h4
   } rmt_tx_state_t;

   // Receive write machine and address comparison.
   rmt_wr_state_t wr_state_r;
   logic [2:0] fld_cnt_r;
   logic da_eq_r, sa_eq_r, ext_sa_r, ext_da_r, strip_r, recv_r;
   logic [15:0] data_len_r;
   logic [1:0] fc_class_r;
   wire [2:0] fld_len = long_addr_in ? ADDR_LONG_BYTES : ADDR_SHORT_BYTES;
   wire [47:0] own_sel = long_addr_in ? station_own_address_in
                                      : {32'h0000_0000, station_own_address_in[15:0]};
   wire [2:0] byte_pos = fld_len - 3'h1 - fld_cnt_r;
   wire [47:0] own_shift = own_sel >> {byte_pos, 3'h0};
   wire byte_eq = (rx_byte_in == own_shift[BYTE_W-1:0]);
   wire fld_end = (fld_cnt_r == fld_len - 3'h1);
   wire rx_go = ce_in && rx_valid_in;
   wire in_addr = (wr_state_r == RW_DA) || (wr_state_r == RW_SA);
   wire sa_final = (wr_state_r == RW_SA) && fld_end;
   wire sa_match = sa_eq_r && byte_eq;
   wire strip_now = sa_match || ext_sa_r || ext_source_match_in;
   wire recv_now = da_eq_r || ext_da_r || !ext_dest_match_in_n;
   wire take_data = (wr_state_r == RW_DATA) && recv_r && !strip_r;

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         wr_state_r <= RW_IDLE;
         fld_cnt_r <= 3'h0;
         da_eq_r <= 1'b0;
         sa_eq_r <= 1'b0;
         ext_sa_r <= 1'b0;
         ext_da_r <= 1'b0;
         strip_r <= 1'b0;
         recv_r <= 1'b0;
         data_len_r <= 16'h0000;
         fc_class_r <= 2'h0;
      end else if (rx_go) begin
         if (in_addr) begin
            ext_sa_r <= ext_sa_r || ext_source_match_in;
            ext_da_r <= ext_da_r || !ext_dest_match_in_n;
            fld_cnt_r <= fld_end ? 3'h0 : fld_cnt_r + 3'h1;
         end
         if (rx_first_in) begin
            wr_state_r <= RW_DA;
            fc_class_r <= rx_byte_in[FC_CLASS_HI:FC_CLASS_LO];
            fld_cnt_r <= 3'h0;
            {da_eq_r, sa_eq_r, ext_sa_r, ext_da_r} <= 4'hF;
            {ext_sa_r, ext_da_r, strip_r, recv_r} <= 4'h0;
            data_len_r <= 16'h0000;
         end else if (rx_last_in) begin
            wr_state_r <= RW_IDLE;
         end else if (wr_state_r == RW_DA) begin
            da_eq_r <= da_eq_r && byte_eq;
            wr_state_r <= fld_end ? RW_SA : RW_DA;
         end else if (wr_state_r == RW_SA) begin
            sa_eq_r <= sa_match;
            if (fld_end) begin
               wr_state_r <= RW_DATA;
               strip_r <= strip_now;
               recv_r <= recv_now;
            end
         end else if (wr_state_r == RW_DATA) begin
            data_len_r <= data_len_r + 16'h0001;
         end
      end
   end

   // Frame status is reported once per frame on its last byte.
   wire fin_strip = sa_final ? strip_now : strip_r;
   wire fin_recv = sa_final ? recv_now : recv_r;
   wire fin_short = (wr_state_r != RW_DATA) || (data_len_r + 16'h0001 < MIN_DATA_BYTES);
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         frame_status_valid_out <= 1'b0;
         frame_status_out <= 5'h00;
         fc_class_out <= 2'h0;
      end else if (ce_in) begin
         frame_status_valid_out <= rx_valid_in && rx_last_in && (wr_state_r != RW_IDLE);
         if (rx_valid_in && rx_last_in && (wr_state_r != RW_IDLE)) begin
            frame_status_out <= {fin_short, fin_strip, fin_recv, ext_sa_r, ext_da_r};
            fc_class_out <= fc_class_r;
         end
      end
   end

   // Byte packing into long words; the completed word waits in one holding stage.
   logic [WORD_W-1:0] pack_r;
   logic [1:0] pack_cnt_r;
   logic wq_valid_r;
   logic [ENTRY_W-1:0] wq_data_r;
   logic fifo_in_ready, fifo_out_valid, fifo_pop;
   logic [ENTRY_W-1:0] fifo_out;
   wire [WORD_W-1:0] pack_nxt = {pack_r[23:0], rx_byte_in};
   wire [WORD_W-1:0] word_aligned = pack_nxt << {~pack_cnt_r, 3'h0};
   wire word_fire = rx_go && take_data && ((pack_cnt_r == PACK_FULL) || rx_last_in);
   wire wq_free = !wq_valid_r || fifo_in_ready;

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pack_r <= '0;
         pack_cnt_r <= 2'h0;
         wq_valid_r <= 1'b0;
         wq_data_r <= '0;
         rx_overflow_out <= 1'b0;
      end else if (ce_in) begin
         if (rx_go && rx_first_in) begin
            pack_cnt_r <= 2'h0;
         end else if (rx_go && take_data) begin
            pack_r <= pack_nxt;
            pack_cnt_r <= rx_last_in ? 2'h0 : pack_cnt_r + 2'h1;
         end
         if (word_fire && wq_free) begin
            wq_valid_r <= 1'b1;
            wq_data_r <= {rx_last_in, word_aligned};
         end else if (fifo_in_ready) begin
            wq_valid_r <= 1'b0;
         end
         rx_overflow_out <= word_fire && !wq_free;
      end
   end

   rmt_fifo #(.WIDTH(ENTRY_W), .DEPTH(RX_FIFO_DEPTH)) u_rx_fifo (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .ce_in(ce_in),
      .in_valid_in(wq_valid_r),
      .in_ready_out(fifo_in_ready),
      .in_data_in(wq_data_r),
      .out_valid_out(fifo_out_valid),
      .out_ready_in(fifo_pop),
      .out_data_out(fifo_out)
   );

   // Read machine: moves FIFO words to buffer memory and holding-register words to and from it.
   rmt_rd_state_t rd_state_r;
   logic [WORD_W-1:0] mdr_r;
   logic store_pend_r, fetch_pend_r;
   wire granted = ce_in && buf_grant_in;
   wire rx_wr = (rd_state_r == RD_RX) && granted;
   wire mdr_wr = (rd_state_r == RD_STORE) && granted;
   assign fifo_pop = rx_wr;
   wire [WORD_W-1:0] wr_word = rx_wr ? fifo_out[WORD_W-1:0] : mdr_r;
   wire [3:0] par_gen;
   wire [3:0] par_bad;
   for (genvar b = 0; b < 4; b++) begin : g_par
      assign par_gen[b] = (^wr_word[8*b +: 8]) ^ parity_odd_in;
      assign par_bad[b] = ((^buffer_data_bus_in[8*b +: 8]) ^ buf_parity_in[b]) != parity_odd_in;
   end
   wire fetch_done = (rd_state_r == RD_FETCH) && buf_rd_valid_in;

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rd_state_r <= RD_IDLE;
         buf_we_out <= 1'b0;
         buffer_data_bus_out <= '0;
         buf_parity_out <= 4'h0;
         buffer_frame_end_tag_out <= 1'b0;
         parity_err_out <= 4'h0;
      end else if (ce_in) begin
         buf_we_out <= rx_wr || mdr_wr;
         buffer_frame_end_tag_out <= rx_wr && tag_mode_in && fifo_out[LAST_BIT];
         if (rx_wr || mdr_wr) begin
            buffer_data_bus_out <= wr_word;
            buf_parity_out <= par_gen;
         end
         parity_err_out <= buf_rd_valid_in ? par_bad : 4'h0;
         unique case (rd_state_r)
            RD_IDLE: begin
               if (fifo_out_valid) begin
                  rd_state_r <= RD_RX;
               end else if (store_pend_r) begin
                  rd_state_r <= RD_STORE;
               end else if (fetch_pend_r) begin
                  rd_state_r <= RD_FETCH;
               end
            end
            RD_RX, RD_STORE: begin
               if (buf_grant_in) begin
                  rd_state_r <= RD_IDLE;
               end
            end
            RD_FETCH: begin
               if (buf_rd_valid_in) begin
                  rd_state_r <= RD_IDLE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         buf_req_out <= 1'b0;
         mdr_r <= '0;
         store_pend_r <= 1'b0;
         fetch_pend_r <= 1'b0;
         np_data_out <= '0;
         mdr_pending_out <= 2'h0;
         chip_reset_out <= 1'b0;
      end else if (ce_in) begin
         buf_req_out <= (rd_state_r != RD_IDLE) && !(granted && rd_state_r != RD_FETCH)
                        && !fetch_done;
         if (np_wr_in && np_half_in) begin
            mdr_r[31:16] <= np_data_in;
         end else if (np_wr_in) begin
            mdr_r[15:0] <= np_data_in;
         end else if (fetch_done) begin
            mdr_r <= buffer_data_bus_in;
         end
         np_data_out <= np_half_in ? mdr_r[31:16] : mdr_r[15:0];
         store_pend_r <= mdr_store_req_in || (store_pend_r && !mdr_wr);
         fetch_pend_r <= mdr_fetch_req_in || (fetch_pend_r && !fetch_done);
         mdr_pending_out <= {fetch_pend_r, store_pend_r};
         chip_reset_out <= np_soft_reset_in;
      end
   end

   // Rotation and valid-transmission timers.
   logic [TW-1:0] trt_r, tvx_r;
   logic trt_once_r;
   wire trt_zero = (trt_r == '0);
   wire tvx_zero = (tvx_r == '0);
   wire [TW-1:0] trt_load = ring_operational_in ? negotiated_rotation_time_in : TRT_INIT;
   wire valid_end = rx_valid_in && rx_last_in;
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         trt_r <= TRT_INIT;
         trt_once_r <= 1'b0;
         tvx_r <= '0;
         late_token_out <= 1'b0;
         claim_start_out <= 1'b0;
         ring_recovery_out <= 1'b0;
      end else if (ce_in) begin
         late_token_out <= token_arrived_in && trt_once_r;
         claim_start_out <= !token_arrived_in && trt_zero && trt_once_r;
         ring_recovery_out <= !(valid_end || token_arrived_in) && tvx_zero;
         if (token_arrived_in) begin
            trt_r <= trt_load;
            trt_once_r <= 1'b0;
         end else if (trt_zero) begin
            trt_r <= trt_load;
            trt_once_r <= !trt_once_r;
         end else begin
            trt_r <= trt_r - 1'b1;
         end
         tvx_r <= (valid_end || token_arrived_in || tvx_zero) ? tvx_max_in : tvx_r - 1'b1;
      end
   end

   // Transmit sequencing while the token is held.
   rmt_tx_state_t tx_state_r;
   logic [TW-1:0] sync_cnt_r;
   logic [1:0] q_r;
   wire [TW-1:0] q_prio = async_prio_in[TW*q_r +: TW];
   wire tht_zero = (tht_out == '0);
   wire q_grant = queue_pending_in[q_r + 2'h1] && (q_prio < tht_out);
   wire sync_over = (sync_cnt_r == '0) || !queue_pending_in[0];
   wire [1:0] q_next = q_r + 2'h1;
   wire cap_go = ce_in && token_capture_in && (tx_state_r == TX_IDLE);

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         tx_state_r <= TX_IDLE;
         sync_cnt_r <= '0;
         q_r <= 2'h0;
         tht_out <= '0;
         tx_queue_out <= TXQ_NONE;
         token_release_out <= 1'b0;
      end else if (ce_in) begin
         token_release_out <= (tx_state_r == TX_RELEASE);
         if (tx_state_r != TX_SYNC && tx_state_r != TX_IDLE && !tht_zero) begin
            tht_out <= tht_out - 1'b1;
         end
         unique case (tx_state_r)
            TX_IDLE: begin
               if (token_capture_in) begin
                  tht_out <= trt_r;
                  sync_cnt_r <= sync_alloc_in;
                  q_r <= 2'h0;
                  tx_state_r <= queue_pending_in[0] ? TX_SYNC : TX_CHECK;
                  tx_queue_out <= queue_pending_in[0] ? TXQ_SYNC : TXQ_NONE;
               end
            end
            TX_SYNC: begin
               sync_cnt_r <= (sync_cnt_r == '0) ? sync_cnt_r : sync_cnt_r - 1'b1;
               if (sync_over) begin
                  tx_state_r <= TX_CHECK;
                  tx_queue_out <= TXQ_NONE;
               end
            end
            TX_CHECK: begin
               if (tht_zero) begin
                  tx_state_r <= TX_RELEASE;
               end else if (q_grant) begin
                  tx_state_r <= TX_ASYNC;
                  tx_queue_out <= TXQ_ASYNC0 + {1'b0, q_r};
               end else if (q_r == LAST_QUEUE) begin
                  tx_state_r <= TX_RELEASE;
               end else begin
                  q_r <= q_next;
               end
            end
            TX_ASYNC: begin
               if (frame_done_in && (tht_zero || !queue_pending_in[q_r + 2'h1])) begin
                  tx_queue_out <= TXQ_NONE;
                  tx_state_r <= (tht_zero || q_r == LAST_QUEUE) ? TX_RELEASE : TX_CHECK;
                  q_r <= (q_r == LAST_QUEUE) ? q_r : q_next;
               end
            end
            TX_RELEASE: begin
               tx_state_r <= TX_IDLE;
            end
            default: begin
               tx_state_r <= TX_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         np_irq_out <= 1'b0;
      end else if (ce_in) begin
         np_irq_out <= late_token_out || claim_start_out || ring_recovery_out
                       || rx_overflow_out || (parity_err_out != 4'h0);
      end
   end

   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);

   sequence cap_seq;
      cap_go && queue_pending_in[0];
   endsequence
   sequence expire_seq;
      ce_in && (tx_state_r == TX_ASYNC) && frame_done_in && tht_zero;
   endsequence

   sync_first_a: assert property (cap_seq |=> tx_queue_out == TXQ_SYNC)
      else $error("sync queue not first after capture");
   tht_hold_a: assert property (ce_in && tx_state_r == TX_SYNC |=> tht_out == $past(tht_out))
      else $error("holding count moved during sync");
   tht_load_a: assert property (cap_go |=> tht_out == $past(trt_r))
      else $error("holding count not loaded at capture");
   async_grant_a: assert property (ce_in && tx_state_r == TX_CHECK && !tht_zero && q_grant
      |=> tx_state_r == TX_ASYNC && tx_queue_out == TXQ_ASYNC0 + {1'b0, $past(q_r)})
      else $error("eligible async queue not granted");
   token_release_a: assert property (expire_seq |=> tx_state_r == TX_RELEASE
      ##1 (!ce_in || token_release_out) [*1])
      else $error("token not released after holding expiry");
   claim_start_a: assert property (ce_in && trt_once_r && trt_zero && !token_arrived_in
      |=> claim_start_out)
      else $error("second expiry did not start claim");
   late_token_a: assert property (ce_in && token_arrived_in |=> late_token_out == $past(trt_once_r))
      else $error("late token flag wrong");
   tvx_expiry_a: assert property (ce_in && tvx_zero && !valid_end && !token_arrived_in
      |=> ring_recovery_out && tvx_r == $past(tvx_max_in))
      else $error("valid-transmission expiry missed");
   write_parity_a: assert property (buf_we_out |-> (^{buffer_data_bus_out[7:0], buf_parity_out[0]})
      == $past(parity_odd_in))
      else $error("write parity wrong");
   tag_write_a: assert property (buffer_frame_end_tag_out |-> buf_we_out && $past(tag_mode_in))
      else $error("tag outside a tagged write");
   word_pack_a: assert property (word_fire && !wq_valid_r |=> wq_valid_r)
      else $error("packed word not queued");
endmodule

// ===== src/rmt_fifo.sv
// Purpose: Shared constants for the ring receive and token timing block, and its word FIFO.
// Assumes: One clock; clock enable freezes all state; asynchronous active-low reset.
// Notes: The FIFO is first-word-fall-through with valid and ready on both sides.
package rmt_pkg;
   localparam int BYTE_W = 8;
   localparam int WORD_W = 32;
   localparam int ENTRY_W = 33;
   localparam int RX_FIFO_DEPTH = 10;
   localparam int TIMER_W = 16;
   localparam int NP_W = 16;
   localparam int LAST_BIT = 32;
   localparam logic [2:0] ADDR_SHORT_BYTES = 3'h2;
   localparam logic [2:0] ADDR_LONG_BYTES = 3'h6;
   localparam logic [15:0] MIN_DATA_BYTES = 16'h0004;
   localparam int FC_CLASS_HI = 7;
   localparam int FC_CLASS_LO = 6;
   localparam logic [2:0] TXQ_NONE = 3'h0;
   localparam logic [2:0] TXQ_SYNC = 3'h4;
   localparam logic [2:0] TXQ_ASYNC0 = 3'h5;
   localparam logic [1:0] LAST_QUEUE = 2'h2;
   localparam logic [1:0] PACK_FULL = 2'h3;
endpackage

`timescale 1ns/1ns
module rmt_fifo #(
   parameter int WIDTH = 33,
   parameter int DEPTH = 10
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic ce_in,
   input wire logic in_valid_in,
   output logic in_ready_out,
   input wire logic [WIDTH-1:0] in_data_in,
   output logic out_valid_out,
   input wire logic out_ready_in,
   output logic [WIDTH-1:0] out_data_out
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr_r;
   logic [AW-1:0] rd_ptr_r;
   logic [AW:0] count_r;
   wire push = ce_in && in_valid_in && in_ready_out;
   wire pop = ce_in && out_valid_out && out_ready_in;
   wire [AW-1:0] wr_inc = (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
   wire [AW-1:0] rd_inc = (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;

   assign in_ready_out = (count_r != (AW + 1)'(DEPTH));
   assign out_valid_out = (count_r != '0);
   assign out_data_out = mem[rd_ptr_r];

   always_ff @(posedge clk_in) begin
      if (push) begin
         mem[wr_ptr_r] <= in_data_in;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r <= '0;
      end else begin
         if (push) begin
            wr_ptr_r <= wr_inc;
         end
         if (pop) begin
            rd_ptr_r <= rd_inc;
         end
         if (push && !pop) begin
            count_r <= count_r + 1'b1;
         end else if (pop && !push) begin
            count_r <= count_r - 1'b1;
         end
      end
   end
endmodule

// ===== sim/rmt_buf_model.sv
// Purpose: Buffer memory stand-in that grants requests and keeps the last write.
// Assumes: Grant moves only on the falling clock edge.
// Notes: Slow mode grants on alternate cycles only.
`timescale 1ns/1ns
module rmt_buf_model (
   input wire logic clk_in,
   input wire logic slow_in,
   input wire logic req_in,
   input wire logic we_in,
   input wire logic [36:0] wr_in,
   output logic gnt_out = 1'b0,
   output logic [36:0] last_out,
   output int n_wr_out = 0
);
   logic ph_r = 1'b0;
   always @(negedge clk_in) begin
      ph_r <= !ph_r;
      gnt_out <= req_in & (!slow_in | ph_r);
   end
   always @(posedge clk_in) begin
      if (we_in === 1'b1) begin
         last_out <= wr_in;
         n_wr_out <= n_wr_out + 1;
      end
   end
endmodule

// ===== sim/rmt_top_tb_top.sv
// Purpose: Self-checking bench for receive matching, packing, parity and claim timing.
// Assumes: Inputs change on the falling edge; short station address.
// Notes: Random data bytes from a fixed seed.
`timescale 1ns/1ns
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_errors++; \
   $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module rmt_top_tb_top;
   import rmt_pkg::*;
   logic clk_in = 0, rst_n_in = 0, ce_in = 1, long_addr_in = 0, ext_source_match_in = 0;
   logic ext_dest_match_in_n = 1, rx_valid_in = 0, rx_first_in = 0, rx_last_in = 0;
   logic ring_operational_in = 0, token_arrived_in = 0, token_capture_in = 0;
   logic frame_done_in = 0, tag_mode_in = 0, parity_odd_in = 0, buf_grant_in, buf_rd_valid_in = 0;
   logic np_half_in = 0, np_wr_in = 0, mdr_store_req_in = 0, mdr_fetch_req_in = 0;
   logic np_soft_reset_in = 0, slow = 0;
   logic [7:0] rx_byte_in = 0;
   logic [47:0] station_own_address_in = 48'h1234, async_prio_in = 0;
   logic [15:0] negotiated_rotation_time_in = 0, sync_alloc_in = 0, np_data_in = 0;
   logic [15:0] tvx_max_in = 16'hFFFF, tht_out, np_data_out;
   logic [3:0] queue_pending_in = 0, buf_parity_in = 0, buf_parity_out, parity_err_out, perr = 0;
   logic [31:0] buffer_data_bus_in = 0, buffer_data_bus_out, w;
   logic frame_status_valid_out, rx_overflow_out, late_token_out, claim_start_out;
   logic ring_recovery_out, token_release_out, buf_req_out, buf_we_out, buffer_frame_end_tag_out;
   logic chip_reset_out, np_irq_out;
   logic [4:0] frame_status_out, st_cap;
   logic [1:0] fc_class_out, mdr_pending_out;
   logic [2:0] tx_queue_out;
   logic [36:0] last;
   int n_errors = 0, n_checks = 0, n_stat = 0, n_claim = 0, n_wr, seed = 32'h96ed;
   int nd_t[5] = '{6, 4, 4, 2, 4};
   int wr_t[5] = '{2, 0, 1, 0, 0};
   logic [15:0] da_t[5] = '{16'h1234, 16'h7777, 16'h7777, 16'h7777, 16'h1234};
   logic [15:0] sa_t[5] = '{16'h5555, 16'h1234, 16'h5555, 16'h1234, 16'h5555};
   logic [4:0] st_t[5] = '{5'h04, 5'h08, 5'h05, 5'h18, 5'h0E};
   rmt_top u_dut (.clk_in, .rst_n_in, .ce_in, .long_addr_in, .station_own_address_in,
      .ext_source_match_in, .ext_dest_match_in_n, .rx_valid_in, .rx_first_in, .rx_last_in,
      .rx_byte_in, .frame_status_valid_out, .frame_status_out, .fc_class_out, .rx_overflow_out,
      .ring_operational_in, .token_arrived_in, .token_capture_in, .negotiated_rotation_time_in,
      .sync_alloc_in, .tvx_max_in, .async_prio_in, .queue_pending_in, .frame_done_in,
      .late_token_out, .claim_start_out, .ring_recovery_out, .token_release_out, .tx_queue_out,
      .tht_out, .tag_mode_in, .parity_odd_in, .buf_grant_in, .buf_req_out, .buf_we_out,
      .buffer_data_bus_out, .buf_parity_out, .buffer_frame_end_tag_out, .buf_rd_valid_in,
      .buffer_data_bus_in, .buf_parity_in, .parity_err_out, .np_data_in, .np_half_in, .np_wr_in,
      .np_data_out, .mdr_store_req_in, .mdr_fetch_req_in, .mdr_pending_out, .np_soft_reset_in,
      .chip_reset_out, .np_irq_out);
   rmt_buf_model u_mem (.clk_in, .slow_in(slow), .req_in(buf_req_out), .we_in(buf_we_out),
      .wr_in({buffer_data_bus_out, buf_parity_out, buffer_frame_end_tag_out}),
      .gnt_out(buf_grant_in), .last_out(last), .n_wr_out(n_wr));
   initial forever #25 clk_in = !clk_in;
   always @(posedge clk_in) begin
      if (frame_status_valid_out === 1'b1) begin
         n_stat++;
         st_cap = frame_status_out;
      end
      if (claim_start_out === 1'b1) n_claim++;
      if (rst_n_in) perr = perr | parity_err_out;
   end
   function automatic logic [3:0] par(logic [31:0] v, logic odd);
      return {^v[31:24] ^ odd, ^v[23:16] ^ odd, ^v[15:8] ^ odd, ^v[7:0] ^ odd};
   endfunction
   task automatic results();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic send(input int k);
      logic [7:0] b[$];
      logic [7:0] d;
      b = {8'h50, da_t[k][15:8], da_t[k][7:0], sa_t[k][15:8], sa_t[k][7:0]};
      w = 32'h0;
      for (int i = 0; i < nd_t[k]; i++) begin
         d = $random(seed);
         b.push_back(d);
         if (i / 4 == (nd_t[k] - 1) / 4) w[31 - 8 * (i % 4) -: 8] = d;
      end
      foreach (b[i]) begin
         @(negedge clk_in);
         {rx_valid_in, rx_first_in, rx_last_in, rx_byte_in} = {1'b1, i == 0, i == b.size() - 1, b[i]};
      end
      @(negedge clk_in);
      {rx_valid_in, rx_last_in, ext_source_match_in, ext_dest_match_in_n} = 4'h1;
   endtask
   initial begin
      repeat (5) @(negedge clk_in);
      rst_n_in = 1;
      for (int k = 0; k < 5; k++) begin
         int wt;
         {tag_mode_in, parity_odd_in, slow} = {k == 0, k == 2, 1'($random(seed))};
         {ext_source_match_in, ext_dest_match_in_n} = {k == 4, k != 2};
         wt = n_wr + wr_t[k];
         send(k);
         for (int c = 0; c < 60 && !(n_stat == k + 1 && n_wr == wt); c++) @(negedge clk_in);
         `CHK(n_stat == k + 1 && n_wr == wt, 1'b1)
         `CHK(st_cap, st_t[k])
         `CHK(fc_class_out, 2'h1)
         if (wr_t[k] > 0) begin
            `CHK(last[36:5], w)
            `CHK(last[4:1], par(w, parity_odd_in))
            `CHK(last[0], tag_mode_in)
         end
         $display("frame test %0d done", k);
      end
      {buf_rd_valid_in, buffer_data_bus_in, parity_odd_in} = {1'b1, 32'h1, 1'b0};
      @(negedge clk_in);
      buf_rd_valid_in = 0;
      @(negedge clk_in);
      `CHK(np_irq_out, 1'b1)
      repeat (2) @(negedge clk_in);
      `CHK(perr, 4'h1)
      {np_wr_in, np_half_in, np_data_in, np_soft_reset_in} = {2'h3, 16'hBEEF, 1'b1};
      @(negedge clk_in);
      {np_half_in, np_data_in, np_soft_reset_in} = {1'b0, 16'h1234, 1'b0};
      `CHK(chip_reset_out, 1'b1)
      @(negedge clk_in);
      {np_wr_in, np_half_in, mdr_store_req_in} = 3'h3;
      @(negedge clk_in);
      mdr_store_req_in = 0;
      `CHK(np_data_out, 16'hBEEF)
      @(negedge clk_in);
      `CHK(mdr_pending_out, 2'h1)
      repeat (8) @(negedge clk_in);
      `CHK({last[36:5], mdr_pending_out}, {32'hBEEF1234, 2'h0})
      {queue_pending_in, sync_alloc_in, token_capture_in} = {4'h3, 16'h0003, 1'b1};
      @(negedge clk_in);
      token_capture_in = 0;
      `CHK(tx_queue_out, TXQ_SYNC)
      repeat (6) @(negedge clk_in);
      `CHK(tx_queue_out, TXQ_ASYNC0)
      {frame_done_in, queue_pending_in} = 5'h10;
      @(negedge clk_in);
      frame_done_in = 0;
      repeat (3) @(negedge clk_in);
      `CHK({token_release_out, tx_queue_out}, {1'b1, TXQ_NONE})
      {ring_operational_in, negotiated_rotation_time_in, token_arrived_in} = {1'b1, 16'h0010, 1'b1};
      @(negedge clk_in);
      token_arrived_in = 0;
      for (int c = 0; c < 80 && n_claim == 0; c++) @(negedge clk_in);
      `CHK(n_claim != 0, 1'b1)
      repeat (20) @(negedge clk_in);
      token_arrived_in = 1;
      @(negedge clk_in);
      token_arrived_in = 0;
      `CHK(late_token_out, 1'b1)
      $display("parity, mdr, transmit and timer test done");
      results();
   end
endmodule
